/* src/phyirq_regs.sv */
// Purpose: interrupt, cable diagnostic and status registers behind
//          the serial management pins
// Assumes: mdc and mdio come from outside and are resynchronised
// Notes:   device answers only its own phy address
module phyirq_regs
  import phyirq_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic [4:0]   phy_addr_i,
  input  wire logic         mdc_i,
  input  wire logic         mdio_i,
  output logic              mdio_o,
  output logic              mdio_oe_n_o,
  input  wire phyirq_evt_s  evt_i,
  input  wire phyirq_stat_s stat_i,
  input  wire logic         diag_done_i,
  input  wire phyirq_diag_s diag_res_i,
  output logic              diag_start_o,
  output logic              irq_o
);

  // ------------------------------------------------------------------
  // frame states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_TA  = 3'b010,
    ST_RD  = 3'b011,
    ST_WR  = 3'b100
  } phyirq_st_e;

  // increment a frame counter, saturating at its top
  function automatic logic [5:0] inc6(input logic [5:0] v);
    inc6 = (v == 6'h3f) ? v : v + 6'h01;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers, change accepted when stages two and three agree
  // ------------------------------------------------------------------
  logic [2:0] mdc_s_q;
  logic [2:0] mdio_s_q;
  logic       mdc_f_q;
  logic       mdio_f_q;
  wire        mdc_ok  = (mdc_s_q[1] == mdc_s_q[2]);
  wire        mdio_ok = (mdio_s_q[1] == mdio_s_q[2]);
  wire        mdc_rise = mdc_ok & mdc_s_q[2] & ~mdc_f_q;
  wire        bit_in   = mdio_ok ? mdio_s_q[2] : mdio_f_q;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mdc_s_q  <= 3'h0;
      mdio_s_q <= 3'h7;
      mdc_f_q  <= 1'b0;
      mdio_f_q <= 1'b1;
    end else begin
      mdc_s_q  <= {mdc_s_q[1:0], mdc_i};
      mdio_s_q <= {mdio_s_q[1:0], mdio_i};
      if (mdc_ok) mdc_f_q <= mdc_s_q[2];
      if (mdio_ok) mdio_f_q <= mdio_s_q[2];
    end
  end

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [7:0]   irq_en_q;
  logic [7:0]   irq_flag_q;
  logic         diag_run_q;
  logic [2:0]   diag_rsv_q;
  phyirq_diag_s diag_q;
  phyirq_stat_s stat_q;

  // ------------------------------------------------------------------
  // frame decoder
  // ------------------------------------------------------------------
  // frame after the preamble: the start zero is taken in the preamble
  // state, then 13 header bits (start one, op, phy, reg) shift in.
  // the turnaround spans two mdc rises, so the device drives zero for
  // the second turnaround bit and data bit 0 still falls in the frame.
  // a shorter turnaround would drop bit 0 on reads and take the
  // turnaround bit as data bit 15 on writes.
  phyirq_st_e  st_q;
  logic [5:0]  cnt_q;
  logic [13:0] hdr_q;
  logic [15:0] sh_q;
  logic        mine_q;

  wire [13:0] hdr_nx   = {hdr_q[12:0], bit_in};
  wire        hdr_end  = (st_q == ST_HDR) && (cnt_q == HDR_BITS - 6'h01);
  wire        hdr_good = (hdr_nx[13:12] == FR_START) &&
                         (hdr_nx[9:5] == phy_addr_i);
  wire        is_rd    = hdr_nx[11:10] == OP_READ;
  wire        is_wr    = hdr_nx[11:10] == OP_WRITE;
  wire [4:0]  reg_a    = hdr_q[4:0];
  wire [4:0]  reg_nx   = hdr_nx[4:0];
  wire        data_end = (cnt_q == DATA_BITS - 6'h01);
  wire [15:0] wr_word  = {sh_q[14:0], bit_in};
  wire        wr_fire  = mdc_rise && (st_q == ST_WR) && data_end && mine_q;
  wire        rd_fire  = mdc_rise && hdr_end && hdr_good && is_rd;

  // second turnaround rise and frame direction after the header
  wire        ta_two   = (st_q == ST_TA) && (cnt_q != 6'h00);
  wire        rd_op    = (hdr_q[11:10] == OP_READ);

  // read data by address; the status word shows ..fields
  wire [15:0] rd_irq  = {irq_en_q, irq_flag_q};
  wire [15:0] rd_diag = {diag_run_q, diag_q.result, diag_q.short_cable,
                         diag_rsv_q, diag_q.distance};
  wire [15:0] rd_stat = {6'h00, stat_q.pause, stat_q.link, stat_q.pol_rev,
                         1'b0, stat_q.mdix, stat_q.energy, stat_q.isolate,
                         stat_q.mode};
  wire [15:0] rd_word = (reg_nx == ADDR_IRQ)  ? rd_irq  :
                        (reg_nx == ADDR_DIAG) ? rd_diag :
                        (reg_nx == ADDR_STAT) ? rd_stat : RD_UNMAPPED;

  // state machine advances on each accepted mdc rise
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q   <= ST_PRE;
      cnt_q  <= 6'h00;
      hdr_q  <= 14'h0000;
      mine_q <= 1'b0;
    end else if (mdc_rise) begin
      case (st_q)
        ST_PRE: begin
          if (bit_in) begin
            cnt_q <= inc6(cnt_q);
          end else if (cnt_q >= PRE_ONES) begin
            st_q  <= ST_HDR;
            hdr_q <= 14'h0000;
            cnt_q <= 6'h01;
          end else begin
            cnt_q <= 6'h00;
          end
        end
        ST_HDR: begin
          hdr_q <= hdr_nx;
          cnt_q <= inc6(cnt_q);
          if (hdr_end) begin
            st_q   <= (is_rd || is_wr) ? ST_TA : ST_PRE;
            mine_q <= hdr_good;
            cnt_q  <= 6'h00;
          end
        end
        // two turnaround rises, counted in cnt_q
        ST_TA: begin
          if (cnt_q == 6'h00) begin
            cnt_q <= 6'h01;
          end else begin
            cnt_q <= 6'h00;
            st_q  <= rd_op ? ST_RD : ST_WR;
          end
        end
        ST_RD, ST_WR: begin
          cnt_q <= inc6(cnt_q);
          if (data_end) begin
            st_q  <= ST_PRE;
            cnt_q <= 6'h00;
          end
        end
        default: begin
          st_q  <= ST_PRE;
          cnt_q <= 6'h00;
        end
      endcase
    end
  end

  // shift register: read snapshot out, write data in
  // bit 15 leaves at the second turnaround rise, so the shift starts
  // there and the last data rise only releases the pin
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      sh_q <= 16'h0000;
    end else if (rd_fire) begin
      sh_q <= rd_word;
    end else if (mdc_rise && ((st_q == ST_RD) || ta_two)) begin
      sh_q <= {sh_q[14:0], 1'b0};
    end else if (mdc_rise && (st_q == ST_WR)) begin
      sh_q <= wr_word;
    end
  end

  // pin driver: zero in second turnaround bit, then data msb first
  // each value changes just after a rise detect, so the master finds
  // it settled when it samples before its next rise
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      mdio_o      <= 1'b1;
      mdio_oe_n_o <= 1'b1;
    end else if (mdc_rise) begin
      if ((st_q == ST_TA) && !ta_two && mine_q && rd_op) begin
        mdio_o      <= 1'b0;
        mdio_oe_n_o <= 1'b0;
      end else if ((((st_q == ST_RD) && !data_end) || ta_two) &&
                   mine_q && rd_op) begin
        mdio_o      <= sh_q[15];
        mdio_oe_n_o <= 1'b0;
      end else if ((st_q == ST_RD) && mine_q && data_end) begin
        mdio_o      <= 1'b1;
        mdio_oe_n_o <= 1'b1;
      end else if (st_q != ST_RD) begin
        mdio_o      <= 1'b1;
        mdio_oe_n_o <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // interrupt bank
  // ------------------------------------------------------------------
  wire wr_irq  = wr_fire && (reg_a == ADDR_IRQ);
  wire rd_irqr = rd_fire && (reg_nx == ADDR_IRQ);
  wire [7:0] evt_v = evt_i;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) irq_en_q <= IRQ_EN_RST;
    else if (wr_irq) irq_en_q <= wr_word[15:IRQ_EN_LSB];
  end

  // sticky flags, read clears, new event wins
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) irq_flag_q <= IRQ_FLAG_RST;
    else irq_flag_q <= (rd_irqr ? 8'h00 : irq_flag_q) | evt_v;
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) irq_o <= 1'b0;
    else irq_o <= |(irq_flag_q & irq_en_q);
  end

  // ------------------------------------------------------------------
  // cable diagnostic
  // ------------------------------------------------------------------
  wire wr_diag   = wr_fire && (reg_a == ADDR_DIAG);
  wire diag_go   = wr_diag && wr_word[DIAG_EN_BIT] && !diag_run_q;
  wire diag_fin  = diag_run_q && diag_done_i;

  // start on write one, self clear on completion
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      diag_run_q   <= 1'b0;
      diag_start_o <= 1'b0;
    end else begin
      diag_start_o <= diag_go;
      if (diag_go) diag_run_q <= 1'b1;
      else if (diag_fin) diag_run_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      diag_q <= '{result: PHYIRQ_DIAG_NORMAL, short_cable: 1'b0,
                  distance: DIST_RST};
    end else if (diag_fin) begin
      diag_q <= diag_res_i;
    end
  end

  // reserved read-write bits of the diagnostic word
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) diag_rsv_q <= DIAG_RSV_RST;
    else if (wr_diag) diag_rsv_q <= wr_word[DIAG_SHORT_BIT-1:DIAG_RSV_LSB];
  end

  // ------------------------------------------------------------------
  // status word
  // ------------------------------------------------------------------
  // live status capture
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      stat_q <= '{pause: 1'b0, link: 1'b0, pol_rev: 1'b0, mdix: 1'b0,
                  energy: 1'b0, isolate: 1'b0, mode: PHYIRQ_MODE_NEG};
    end else begin
      stat_q <= stat_i;
    end
  end

endmodule // phyirq_regs

/* src/phyirq_pkg.sv */
// Purpose: constants and carrier types for the phy management bank
// Assumes: 16-bit registers on a serial management frame
// Notes:   all offsets, irq and diag field positions and the irq, reserved and distance reset values live here; status layout and reset sit in the module
package phyirq_pkg;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [4:0] ADDR_IRQ  = 5'h1b; // enables and flags
  localparam logic [4:0] ADDR_DIAG = 5'h1d; // cable diagnostic
  localparam logic [4:0] ADDR_STAT = 5'h1e; // status word

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int IRQ_EN_LSB      = 8;  // enables in 15:8
  localparam int DIAG_EN_BIT     = 15; // test enable, self clearing
  localparam int DIAG_RES_LSB    = 13; // result in 14:13
  localparam int DIAG_SHORT_BIT  = 12;
  localparam int DIAG_RSV_LSB    = 9;  // reserved rw 11:9
  localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
  localparam logic [7:0]  IRQ_FLAG_RST = 8'h00;
  localparam logic [2:0]  DIAG_RSV_RST = 3'h0;
  localparam logic [8:0]  DIST_RST     = 9'h000;
  localparam logic [15:0] RD_UNMAPPED  = 16'h0000;

  // ------------------------------------------------------------------
  // frame fields and counts
  // ------------------------------------------------------------------
  localparam logic [5:0] PRE_ONES  = 6'h20; // 32 preamble ones
  localparam logic [5:0] HDR_BITS  = 6'h0e; // st, op, phy, reg
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] FR_START  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;

  // diagnostic outcome codes
  typedef enum logic [1:0] {
    PHYIRQ_DIAG_NORMAL = 2'b00,
    PHYIRQ_DIAG_OPEN   = 2'b01,
    PHYIRQ_DIAG_SHORT  = 2'b10,
    PHYIRQ_DIAG_FAIL   = 2'b11
  } phyirq_diag_e;

  // resolved operating mode codes, others reserved
  typedef enum logic [2:0] {
    PHYIRQ_MODE_NEG    = 3'b000,
    PHYIRQ_MODE_10H    = 3'b001,
    PHYIRQ_MODE_100H   = 3'b010,
    PHYIRQ_MODE_10F    = 3'b101,
    PHYIRQ_MODE_100F   = 3'b110
  } phyirq_mode_e;

  // event sources, bit order matches the flag field 7:0
  typedef struct packed {
    logic jabber;
    logic rx_err;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic rem_fault;
    logic link_up;
  } phyirq_evt_s;

  // live status from the transceiver core
  typedef struct packed {
    logic         pause;
    logic         link;
    logic         pol_rev;
    logic         mdix;
    logic         energy;
    logic         isolate;
    phyirq_mode_e mode;
  } phyirq_stat_s;

  // measurement result from the analog tester
  typedef struct packed {
    phyirq_diag_e result;
    logic         short_cable;
    logic [8:0]   distance;
  } phyirq_diag_s;

endpackage : phyirq_pkg

/* bench/phyirq_regs_asserts.sv */
// Purpose: port checks for the phy management bank
// Assumes: mdc phases of eight reference clocks
// Notes:   bound from the bench top file
module phyirq_regs_asserts
  import phyirq_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_o,
  input  wire logic        mdio_oe_n_o,
  input  wire phyirq_evt_s evt_i,
  input  wire logic        diag_start_o,
  input  wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // mdc pin high now or one clock ago
  sequence s_mdc_hi;
    mdc_i || $past(mdc_i);
  endsequence
  // some event two clocks back
  sequence s_evt2;
    $past(|evt_i, 2);
  endsequence

  property p_rst;
    disable iff (1'b0) srst_i |=> !irq_o && mdio_oe_n_o && !diag_start_o;
  endproperty
  property p_pulse;
    diag_start_o |=> !diag_start_o;
  endproperty
  property p_start;
    diag_start_o |-> s_mdc_hi;
  endproperty
  property p_rel;
    mdio_oe_n_o |-> mdio_o;
  endproperty
  property p_ta;
    $fell(mdio_oe_n_o) |-> !mdio_o;
  endproperty
  property p_oe;
    $changed(mdio_oe_n_o) |-> mdc_i;
  endproperty
  property p_irq_up;
    $rose(irq_o) |-> s_evt2 or s_mdc_hi;
  endproperty
  property p_irq_dn;
    $fell(irq_o) |-> s_mdc_hi;
  endproperty

  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_pulse: assert property (p_pulse) else $error("start too long");
  a_start: assert property (p_start) else $error("stray start");
  a_rel: assert property (p_rel) else $error("idle data low");
  a_ta: assert property (p_ta) else $error("turnaround not 0");
  a_oe: assert property (p_oe) else $error("enable off mdc");
  a_irq_up: assert property (p_irq_up) else $error("irq no cause");
  a_irq_dn: assert property (p_irq_dn) else $error("irq drop");
endmodule // phyirq_regs_asserts

/* bench/phyirq_mdio_master.sv */
// Purpose: station management master making mdc and frames
// Assumes: pin resolved with a pull-up in the bench
// Notes:   mdc stands low between frames, 80 ns phases
module phyirq_mdio_master
  import phyirq_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic mdio_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      mdio_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_n_o = 1'b1;
  end

  // one bit: data set in low phase, sampled just before rise
  task automatic bit_cyc(input logic drv, input logic v, output logic s);
    @(negedge clk_i);
    mdc_o = 1'b0;
    mdio_oe_n_o = !drv;
    mdio_o = v;
    repeat (8) @(negedge clk_i);
    s = mdio_i;
    mdc_o = 1'b1;
    repeat (7) @(negedge clk_i);
  endtask

  // preamble, header, turnaround, data msb first
  task automatic frame(input logic rd, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rdv);
    logic [63:0] f;
    logic        s;
    f = {32'hffffffff, FR_START, rd ? OP_READ : OP_WRITE, pa, ra,
         2'b10, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cyc(!rd || i > 17, f[i], s);
      if (i < 16) rdv[i] = s;
    end
    @(negedge clk_i);
    mdc_o = 1'b0;
    mdio_oe_n_o = 1'b1;
  endtask
endmodule // phyirq_mdio_master

/* bench/phyirq_regs_tb.sv */
// Purpose: self-checking bench for the phy management bank
// Assumes: mdio pin pulled up when nobody drives it
// Notes:   all register traffic goes through the partner
module phyirq_regs_tb
  import phyirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         diag_done_i = 1'b0;
  logic [4:0]   phy_addr_i = 5'h03;
  phyirq_evt_s  evt_i = '0;
  phyirq_stat_s stat_i = '0;
  phyirq_diag_s diag_res_i = '0;
  logic         mdc, m_mdio, m_oe_n, d_mdio, d_oe_n, start, irq;
  logic [15:0]  rv;
  int           fail_count = 0;
  int           n_compared = 0;
  int           n_start = 0;
  phyirq_mode_e modes [5] = '{PHYIRQ_MODE_NEG, PHYIRQ_MODE_10H,
    PHYIRQ_MODE_100H, PHYIRQ_MODE_10F, PHYIRQ_MODE_100F};
  wire logic    pin;

  // pin level from both enables, pull-up when idle
  assign pin = !d_oe_n ? d_mdio : (!m_oe_n ? m_mdio : 1'b1);

  phyirq_regs i_phyirq_regs (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .phy_addr_i(phy_addr_i), .mdc_i(mdc), .mdio_i(pin),
    .mdio_o(d_mdio), .mdio_oe_n_o(d_oe_n), .evt_i(evt_i),
    .stat_i(stat_i), .diag_done_i(diag_done_i),
    .diag_res_i(diag_res_i), .diag_start_o(start), .irq_o(irq));
  phyirq_mdio_master i_phyirq_mdio_master (.clk_i(ref_clk_i),
    .mdio_i(pin), .mdc_o(mdc), .mdio_o(m_mdio), .mdio_oe_n_o(m_oe_n));

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // count test start pulses
  always @(posedge ref_clk_i)
    if (start) n_start++;

  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    i_phyirq_mdio_master.frame(1'b1, phy_addr_i, ra, 16'h0, d);
  endtask
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e,
                     input string nm);
    logic [15:0] d;
    rd(ra, d);
    chk(nm, e, d);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    i_phyirq_mdio_master.frame(1'b0, phy_addr_i, ra, d, x);
  endtask
  task automatic pulse(input int j);
    @(negedge ref_clk_i);
    evt_i = phyirq_evt_s'(8'h01 << j);
    @(negedge ref_clk_i);
    evt_i = '0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk_i);
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    rdc(ADDR_IRQ, 16'h0000, "irq reset");
    rdc(ADDR_DIAG, 16'h0000, "diag reset");
    rdc(5'h1c, RD_UNMAPPED, "unmapped");
    // status word across every mode code
    for (int k = 0; k < 5; k++) begin
      stat_i = {k[0], !k[0], k[1], !k[1], k[0], !k[0], modes[k]};
      rdc(ADDR_STAT, {6'h00, stat_i.pause, stat_i.link, stat_i.pol_rev,
          1'b0, stat_i.mdix, stat_i.energy, stat_i.isolate, stat_i.mode},
          "status");
    end
    wr(ADDR_IRQ, 16'h81ff);
    rdc(ADDR_IRQ, 16'h8100, "enables");
    // each source in turn, two of them enabled
    for (int j = 0; j < 8; j++) begin
      pulse(j);
      chk("irq out", {15'h0, j == 0 || j == 7}, {15'h0, irq});
      if (j == 7) begin
        i_phyirq_mdio_master.frame(1'b1, phy_addr_i + 5'h01, ADDR_IRQ,
                                   16'h0, rv);
        chk("foreign", 16'hffff, rv);
      end
      rdc(ADDR_IRQ, 16'h8100 | (16'h0001 << j), "flags");
      chk("irq clear", 16'h0000, {15'h0, irq});
    end
    rdc(ADDR_IRQ, 16'h8100, "flags clear");
    // diagnostic run for every outcome code
    for (int c = 0; c < 4; c++) begin
      diag_res_i = {c[1:0], c[0], 9'h0a5 + 9'(c)};
      wr(ADDR_DIAG, 16'hf000 | 16'(c << 9));
      chk("starts", 16'(c + 1), 16'(n_start));
      rd(ADDR_DIAG, rv);
      chk("running", 16'h0001, {15'h0, rv[15]});
      @(negedge ref_clk_i);
      diag_done_i = 1'b1;
      @(negedge ref_clk_i);
      diag_done_i = 1'b0;
      for (int p = 0; p < 4 && rv[15]; p++) rd(ADDR_DIAG, rv);
      chk("result", {1'b0, diag_res_i.result, diag_res_i.short_cable,
          3'(c), diag_res_i.distance}, rv);
    end
    // mid-run reset with a flag, enables and results all non-zero
    pulse(1);
    srst_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    rdc(ADDR_IRQ, 16'h0000, "irq mid reset");
    rdc(ADDR_DIAG, 16'h0000, "diag mid reset");
    finish_test();
  end
endmodule // phyirq_regs_tb

bind phyirq_regs phyirq_regs_asserts i_phyirq_regs_asserts (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .mdc_i(mdc_i),
  .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .evt_i(evt_i),
  .diag_start_o(diag_start_o), .irq_o(irq_o));
